//--- pkg/pdwc_params.svh
// timing counts, widths and flag reset values for the power-down wake controller
`ifndef PDWC_PARAMS_SVH
`define PDWC_PARAMS_SVH
`define PDWC_PA_WIDTH       8
`define PDWC_NUM_IRQ        8
`define PDWC_SETTLE_NS      2000
`define PDWC_CLK_NS         50
`define PDWC_SETTLE_CYC     ((`PDWC_SETTLE_NS + `PDWC_CLK_NS - 1) / `PDWC_CLK_NS)
`define PDWC_CNT_W          8
`define PDWC_PDF_RST        1'b0
`define PDWC_TO_RST         1'b0
`endif

//--- pkg/pdwc_pkg.sv
// types for the power-down wake controller
package pdwc_pkg;
	typedef enum logic [2:0] {
		PDWC_RUN   = 3'b000,
		PDWC_SLEEP = 3'b001,
		PDWC_IDLE_MODE_0 = 3'b010,
		PDWC_IDLE_MODE_1 = 3'b011,
		PDWC_IDLE_MODE_2 = 3'b100,
		PDWC_WAKE  = 3'b101
	} pdwc_state_t;
	typedef enum logic [1:0] {
		PDWC_SRC_NONE = 2'b00,
		PDWC_SRC_PORT = 2'b01,
		PDWC_SRC_IRQ  = 2'b10,
		PDWC_SRC_WDT  = 2'b11
	} pdwc_src_t;
endpackage : pdwc_pkg

//--- logic/pdwc_sync.sv
// two-flop synchroniser for one pin
`timescale 1ns/1ns
`default_nettype none
module pdwc_sync (
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q   <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pdwc_sync
`default_nettype wire

//--- logic/pdwc_ctrl.sv
// power-down mode selection, clock gating, status flags and wake control
// Notes on behaviour
// - both keep bits low: sleep, only watchdog
// - fast low, slow high: idle_mode_0, sub only
// - both keep bits high: idle_mode_1, both clocks
// - fast high, slow low: idle_mode_2, fast only
// - halt stops execution, state kept
// - halt sets powerdown flag, clears timeout
// - entering low power clears watchdog counter
// - wake on port edge, interrupt, watchdog
// - powerdown flag cleared by reset, clear-watchdog
// - watchdog wake sets timeout, resets pc/sp
// - per-pin port wake enable, resume after halt
// - disabled or stack-full irq: resume, stays pending
// - enabled irq with stack room: vector
// - irq flag set before halt cannot wake
// - wait for oscillator stable before resuming
// - fast stable flag clears while fast clock is disabled, gates return
`include "pdwc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pdwc_ctrl (
	input  wire logic                        sys_clk,
	input  wire logic                        arst_n,
	input  wire logic                        halt_op,
	input  wire logic                        clear_watchdog_op,
	input  wire logic                        fast_osc_idle_keep,
	input  wire logic                        slow_osc_idle_keep,
	input  wire logic [`PDWC_PA_WIDTH-1:0]   porta_pins,
	input  wire logic [`PDWC_PA_WIDTH-1:0]   porta_wake_mask,
	input  wire logic [`PDWC_NUM_IRQ-1:0]    irq_req,
	input  wire logic [`PDWC_NUM_IRQ-1:0]    irq_en,
	input  wire logic                        stack_full,
	input  wire logic                        wdt_overflow,
	output logic                             cpu_run,
	output logic                             fast_clk_en,
	output logic                             sub_clk_en,
	output logic                             fast_osc_stable,
	output logic                             powerdown_flag,
	output logic                             watchdog_timeout_flag,
	output logic                             wdt_clear,
	output logic                             pc_sp_reset,
	output logic                             irq_vector,
	output logic [1:0]                       wake_source
);
	pdwc_pkg::pdwc_state_t state_q;
	pdwc_pkg::pdwc_src_t   src_q;
	logic [`PDWC_PA_WIDTH-1:0] pa_sync;
	logic [`PDWC_PA_WIDTH-1:0] pa_prev_q;
	logic [`PDWC_NUM_IRQ-1:0]  irq_mask_q;
	logic [`PDWC_CNT_W-1:0]    settle_q;
	logic                      low_power;
	logic                      port_wake;
	logic                      irq_wake;
	logic                      any_wake;
	logic                      resume;
	localparam logic [`PDWC_CNT_W-1:0] SETTLE = `PDWC_CNT_W'(`PDWC_SETTLE_CYC);

	genvar gi;
	generate
		for (gi = 0; gi < `PDWC_PA_WIDTH; gi++) begin : g_pa
			pdwc_sync u_sync (
				.sys_clk (sys_clk),
				.arst_n  (arst_n),
				.async_in(porta_pins[gi]),
				.sync_out(pa_sync[gi])
			);
		end
	endgenerate

	assign low_power = (state_q != pdwc_pkg::PDWC_RUN) && (state_q != pdwc_pkg::PDWC_WAKE);
	// falling edge only on pins whose wake bit is set
	assign port_wake = |(pa_prev_q & ~pa_sync & porta_wake_mask);
	// requests already pending at halt are masked off
	assign irq_wake  = |(irq_req & ~irq_mask_q);
	assign any_wake  = low_power && (port_wake || irq_wake || wdt_overflow);
	assign resume    = (state_q == pdwc_pkg::PDWC_WAKE) && fast_osc_stable;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pa_prev_q <= {`PDWC_PA_WIDTH{1'b1}};
		end else begin
			pa_prev_q <= pa_sync;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask_q <= '0;
		end else if (halt_op && state_q == pdwc_pkg::PDWC_RUN) begin
			irq_mask_q <= irq_req;
		end
	end

	// mode is latched once at halt and held until a wake
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= pdwc_pkg::PDWC_RUN;
		end else begin
			unique case (state_q)
				pdwc_pkg::PDWC_RUN: begin
					if (halt_op) begin
						unique case ({fast_osc_idle_keep, slow_osc_idle_keep})
							2'b00: state_q <= pdwc_pkg::PDWC_SLEEP;
							2'b01: state_q <= pdwc_pkg::PDWC_IDLE_MODE_0;
							2'b11: state_q <= pdwc_pkg::PDWC_IDLE_MODE_1;
							2'b10: state_q <= pdwc_pkg::PDWC_IDLE_MODE_2;
						endcase
					end
				end
				pdwc_pkg::PDWC_SLEEP, pdwc_pkg::PDWC_IDLE_MODE_0,
				pdwc_pkg::PDWC_IDLE_MODE_1, pdwc_pkg::PDWC_IDLE_MODE_2: begin
					if (any_wake) begin
						state_q <= pdwc_pkg::PDWC_WAKE;
					end
				end
				pdwc_pkg::PDWC_WAKE: begin
					if (resume) begin
						state_q <= pdwc_pkg::PDWC_RUN;
					end
				end
				default: state_q <= pdwc_pkg::PDWC_RUN;
			endcase
		end
	end

	// wdt has priority so its pc/sp reset is never lost to a coincident edge
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			src_q <= pdwc_pkg::PDWC_SRC_NONE;
		end else if (any_wake) begin
			if (wdt_overflow) begin
				src_q <= pdwc_pkg::PDWC_SRC_WDT;
			end else if (irq_wake) begin
				src_q <= pdwc_pkg::PDWC_SRC_IRQ;
			end else begin
				src_q <= pdwc_pkg::PDWC_SRC_PORT;
			end
		end else if (resume) begin
			src_q <= pdwc_pkg::PDWC_SRC_NONE;
		end
	end
	assign wake_source = src_q;

	// fast oscillator off only in sleep and idle_mode_0
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_clk_en <= 1'b1;
			sub_clk_en  <= 1'b1;
		end else if (state_q == pdwc_pkg::PDWC_RUN && halt_op) begin
			fast_clk_en <= fast_osc_idle_keep;
			sub_clk_en  <= slow_osc_idle_keep;
		end else if (any_wake) begin
			fast_clk_en <= 1'b1;
			sub_clk_en  <= 1'b1;
		end
	end

	// stable flag drops with the oscillator and rises after a settle count
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			settle_q        <= '0;
			fast_osc_stable <= 1'b1;
		end else begin
			if (!fast_clk_en) begin
				fast_osc_stable <= 1'b0;
				settle_q        <= '0;
			end else if (!fast_osc_stable) begin
				if (settle_q == SETTLE - `PDWC_CNT_W'(1)) begin
					fast_osc_stable <= 1'b1;
				end else begin
					settle_q <= settle_q + `PDWC_CNT_W'(1);
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			powerdown_flag <= `PDWC_PDF_RST;
		end else if (state_q == pdwc_pkg::PDWC_RUN && halt_op) begin
			powerdown_flag <= 1'b1;
		end else if (clear_watchdog_op) begin
			powerdown_flag <= 1'b0;
		end
	end

	// wdt overflow in low power sets timeout; set beats clear at halt
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			watchdog_timeout_flag <= `PDWC_TO_RST;
		end else if (low_power && wdt_overflow) begin
			watchdog_timeout_flag <= 1'b1;
		end else if (state_q == pdwc_pkg::PDWC_RUN && halt_op) begin
			watchdog_timeout_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wdt_clear   <= 1'b0;
			pc_sp_reset <= 1'b0;
			irq_vector  <= 1'b0;
		end else begin
			wdt_clear   <= (state_q == pdwc_pkg::PDWC_RUN) && halt_op;
			pc_sp_reset <= resume && src_q == pdwc_pkg::PDWC_SRC_WDT;
			// disabled or stack-full: plain resume, request left pending in core
			irq_vector  <= resume && src_q == pdwc_pkg::PDWC_SRC_IRQ
				&& |(irq_req & irq_en & ~irq_mask_q) && !stack_full;
		end
	end

	// core holds at the halt with memory and ports untouched
	assign cpu_run = (state_q == pdwc_pkg::PDWC_RUN);

	property p_halt_flags;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_q == pdwc_pkg::PDWC_RUN && halt_op) |=> powerdown_flag && wdt_clear;
	endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("halt flags");

	property p_sleep_clocks;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_q == pdwc_pkg::PDWC_SLEEP) |-> !fast_clk_en && !sub_clk_en && !cpu_run;
	endproperty
	a_sleep_clocks: assert property (p_sleep_clocks) else $error("sleep clocks");

	property p_idle_mode_0;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_q == pdwc_pkg::PDWC_IDLE_MODE_0) |-> !fast_clk_en && sub_clk_en;
	endproperty
	a_idle_mode_0: assert property (p_idle_mode_0) else $error("idle_mode_0 clocks");

	property p_idle_mode_1;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_q == pdwc_pkg::PDWC_IDLE_MODE_1) |-> fast_clk_en && sub_clk_en && !cpu_run;
	endproperty
	a_idle_mode_1: assert property (p_idle_mode_1) else $error("idle_mode_1 clocks");

	property p_idle_mode_2;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_q == pdwc_pkg::PDWC_IDLE_MODE_2) |-> fast_clk_en && !sub_clk_en;
	endproperty
	a_idle_mode_2: assert property (p_idle_mode_2) else $error("idle_mode_2 clocks");

	property p_wdt_wake;
		@(posedge sys_clk) disable iff (!arst_n)
		(low_power && wdt_overflow) |=> watchdog_timeout_flag
			&& state_q == pdwc_pkg::PDWC_WAKE;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake");

	property p_pdf_hold;
		@(posedge sys_clk) disable iff (!arst_n)
		($fell(powerdown_flag)) |-> $past(clear_watchdog_op);
	endproperty
	a_pdf_hold: assert property (p_pdf_hold) else $error("pdf cleared");

	property p_resume_stable;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_q == pdwc_pkg::PDWC_WAKE && !fast_osc_stable) |=> !cpu_run;
	endproperty
	a_resume_stable: assert property (p_resume_stable) else $error("early resume");

	property p_stable_time;
		@(posedge sys_clk) disable iff (!arst_n)
		$rose(fast_clk_en) |-> !fast_osc_stable [*8];
	endproperty
	a_stable_time: assert property (p_stable_time) else $error("stable early");
endmodule : pdwc_ctrl
`default_nettype wire

//--- verif/pdwc_core_model.sv
// core-side model: issues halt while running, counts irq vector and pc/sp reset pulses
`timescale 1ns/1ns
`default_nettype none
module pdwc_core_model (
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic cpu_run,
	input  wire logic go_halt,
	input  wire logic irq_vector,
	input  wire logic pc_sp_reset,
	output logic      halt_op,
	output int        vec_cnt,
	output int        pcsp_cnt
);
	// a stopped core cannot issue another halt
	assign halt_op = go_halt & cpu_run;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			vec_cnt  <= 0;
			pcsp_cnt <= 0;
		end else begin
			vec_cnt  <= vec_cnt + int'(irq_vector);
			pcsp_cnt <= pcsp_cnt + int'(pc_sp_reset);
		end
	end
endmodule : pdwc_core_model
`default_nettype wire

//--- verif/power_down_wake_control_test.sv
// self-checking bench for the power-down wake controller
`timescale 1ns/1ns
`default_nettype none
module power_down_wake_control_test;
	logic       sys_clk = 1'h0;
	logic       arst_n = 1'h0;
	logic       go_halt = 1'h0;
	logic       clear_watchdog_op = 1'h0;
	logic       fast_osc_idle_keep = 1'h0;
	logic       slow_osc_idle_keep = 1'h0;
	logic       stack_full = 1'h0;
	logic       wdt_overflow = 1'h0;
	logic [7:0] porta_pins = 8'hFF;
	logic [7:0] porta_wake_mask = 8'h0F;
	logic [7:0] irq_req = 8'h00;
	logic [7:0] irq_en = 8'h00;
	logic       halt_op, cpu_run, fast_clk_en, sub_clk_en, fast_osc_stable;
	logic       powerdown_flag, watchdog_timeout_flag, wdt_clear, pc_sp_reset, irq_vector;
	logic [1:0] wake_source, seen_src;
	int         vec_cnt, pcsp_cnt, n;
	int         mismatches = 0;
	int         samples_checked = 0;
	always #25 sys_clk = ~sys_clk;
	pdwc_ctrl u_pdwc_ctrl (.sys_clk, .arst_n, .halt_op, .clear_watchdog_op, .fast_osc_idle_keep,
		.slow_osc_idle_keep, .porta_pins, .porta_wake_mask, .irq_req, .irq_en, .stack_full,
		.wdt_overflow, .cpu_run, .fast_clk_en, .sub_clk_en, .fast_osc_stable, .powerdown_flag,
		.watchdog_timeout_flag, .wdt_clear, .pc_sp_reset, .irq_vector, .wake_source);
	pdwc_core_model u_pdwc_core_model (.sys_clk, .arst_n, .cpu_run, .go_halt, .irq_vector,
		.pc_sp_reset, .halt_op, .vec_cnt, .pcsp_cnt);
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task test_done;
		if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	task halt(input logic f, input logic s);
		@(posedge sys_clk);
		fast_osc_idle_keep <= f;
		slow_osc_idle_keep <= s;
		go_halt <= 1'h1;
		@(posedge sys_clk);
		go_halt <= 1'h0;
		// flip the keep bits: the latched mode must not follow
		fast_osc_idle_keep <= ~f;
		slow_osc_idle_keep <= ~s;
		#1;
		chk(cpu_run, 1'h0);
		chk(fast_clk_en, f);
		chk(sub_clk_en, s);
		chk(powerdown_flag, 1'h1);
		chk(watchdog_timeout_flag, 1'h0);
		chk(wdt_clear, 1'h1);
		@(posedge sys_clk);
		#1;
		chk({fast_clk_en, sub_clk_en}, {f, s});
		chk(fast_osc_stable, f);
		chk(wdt_clear, 1'h0);
	endtask : halt
	// bounded wait for resume, remembering the reported source
	task wake(output int cnt);
		cnt = 0;
		seen_src = 2'h0;
		while (cpu_run !== 1'h1 && cnt < 200) begin
			@(posedge sys_clk);
			#1;
			cnt++;
			if (wake_source !== 2'h0) seen_src = wake_source;
		end
		if (cnt >= 200) mismatches++;
		chk({fast_osc_stable, fast_clk_en, sub_clk_en}, 8'h07);
		// one more edge so the core model has counted the resume pulse
		@(posedge sys_clk);
		#1;
	endtask : wake
	initial begin
		#(5000 * 50);
		mismatches++;
		test_done();
	end
	initial begin
		@(posedge sys_clk);
		#1;
		chk({powerdown_flag, watchdog_timeout_flag, wake_source}, 8'h00);
		@(posedge sys_clk);
		arst_n <= 1'h1;
		for (int k = 0; k < 4; k++) begin
			halt(k[1], k[0]);
			@(posedge sys_clk);
			porta_pins <= 8'h7F;
			repeat (8) @(posedge sys_clk);
			#1;
			chk(cpu_run, 1'h0);
			@(posedge sys_clk);
			porta_pins <= 8'h7F & ~(8'h01 << k);
			wake(n);
			chk(seen_src, 2'h1);
			chk(n >= 40, !k[1]);
			chk(8'(vec_cnt), 8'h00);
			chk(8'(pcsp_cnt), 8'h00);
			@(posedge sys_clk);
			porta_pins <= 8'hFF;
		end
		chk(powerdown_flag, 1'h1);
		clear_watchdog_op <= 1'h1;
		@(posedge sys_clk);
		clear_watchdog_op <= 1'h0;
		#1;
		chk(powerdown_flag, 1'h0);
		halt(1'h0, 1'h0);
		@(posedge sys_clk);
		wdt_overflow <= 1'h1;
		@(posedge sys_clk);
		wdt_overflow <= 1'h0;
		wake(n);
		chk(seen_src, 2'h3);
		chk({watchdog_timeout_flag, powerdown_flag}, 2'h3);
		chk(8'(pcsp_cnt), 8'h01);
		// enabled with room, disabled, enabled with stack full
		for (int j = 0; j < 3; j++) begin
			@(posedge sys_clk);
			irq_en <= {7'h00, j != 1};
			stack_full <= (j == 2);
			halt(1'h1, 1'h0);
			@(posedge sys_clk);
			irq_req <= 8'h01;
			wake(n);
			chk(seen_src, 2'h2);
			chk(8'(vec_cnt), 8'h01);
			@(posedge sys_clk);
			irq_req <= 8'h00;
		end
		@(posedge sys_clk);
		irq_req <= 8'h01;
		halt(1'h1, 1'h1);
		repeat (8) @(posedge sys_clk);
		#1;
		chk(cpu_run, 1'h0);
		@(posedge sys_clk);
		porta_pins <= 8'hFE;
		wake(n);
		chk(seen_src, 2'h1);
		test_done();
	end
endmodule : power_down_wake_control_test
`default_nettype wire
